// *** rtl/scr_regs.sv ***
/*
 * Standard serial configuration and identification register bank
 * behind a four-wire serial port (mode 0: sample on rising clock,
 * shift out on falling clock, 16-bit instruction then data bytes).
 * Assumes the serial pins are asynchronous and toggle slowly enough
 * for the three-stage filter on sys_clk (sclk at most sys_clk / 8).
 */
`timescale 1ns/100ps
`default_nettype none
`include "scr_defs.svh"
module scr_regs
   import scr_pkg::*;
#(
   parameter logic [3:0]  PART_CLASS  = 4'h5,     // arbitrary value
   parameter logic [15:0] PART_NUMBER = 16'hA5C3, // arbitrary value
   parameter logic [7:0]  SILICON_REV = 8'h11,    // arbitrary value
   parameter logic [15:0] MAKER_CODE  = 16'h7E21, // arbitrary value
   parameter int          SOFT_RST_CYCLES = `SCR_SOFT_RST_CYC
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic spiSclk,
   input  wire logic spiCsN,
   input  wire logic spiSdi,
   output logic      spiSdo,
   output logic      spiSdoOe,
   output logic      devSoftReset,
   output logic      powerDown
);
   scr_pins_t   pinsIn;
   scr_pins_t   pinsSync;
   logic [2:0]  syncBits;
   logic        sclkPrev;
   logic        sclkRise;
   logic        sclkFall;
   logic        csActive;
   scr_state_t  state;
   logic [3:0]  bitCnt;
   logic [15:0] rxShift;
   logic [15:0] rxNext;
   logic [7:0]  txShift;
   scr_cmd_t    cmd;
   logic [14:0] curAddr;
   logic [14:0] next_addr;
   logic        cmdDone;
   logic        byteDone;
   logic        wrStrobe;
   logic        softStart;
   logic        softActive;
   logic        addrDir;
   logic [1:0]  powerState;
   logic [7:0]  userCfg;

   if (SOFT_RST_CYCLES < 1) begin : g_chk
      $error("scr_regs needs SOFT_RST_CYCLES of one or more");
   end

   // read-back image of the map; unmapped and reserved bytes read zero
   function automatic logic [7:0] readByte(input logic [14:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `SCR_ADDR_SERIAL_CFG: begin
            d[`SCR_BIT_ADDR_DIR]  = addrDir;
            d[`SCR_BIT_FOUR_WIRE] = 1'b1;
         end
         `SCR_ADDR_POWER_CFG:   d = {6'h00, powerState};
         `SCR_ADDR_PART_CLASS:  d = {4'h0, PART_CLASS};
         `SCR_ADDR_PART_NUM_LO: d = PART_NUMBER[7:0];
         `SCR_ADDR_PART_NUM_HI: d = PART_NUMBER[15:8];
         `SCR_ADDR_SILICON_REV: d = SILICON_REV;
         `SCR_ADDR_MAKER_LO:    d = MAKER_CODE[7:0];
         `SCR_ADDR_MAKER_HI:    d = MAKER_CODE[15:8];
         `SCR_ADDR_USER_CFG:    d = userCfg;
         default:               d = 8'h00;
      endcase
      return d;
   endfunction

   // pins pass the three-stage filter before any use
   assign pinsIn.sclk = spiSclk;
   assign pinsIn.csN  = spiCsN;
   assign pinsIn.sdi  = spiSdi;

   scr_sync #(
      .WIDTH   (3),
      .RST_VAL (3'h2)
   ) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .asyncIn (pinsIn),
      .syncOut (syncBits)
   );
   assign pinsSync = scr_pins_t'(syncBits);

   // clock edge detection on the filtered clock
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sclkPrev <= 1'b0;
      end else begin
         sclkPrev <= pinsSync.sclk;
      end
   end
   assign sclkRise = pinsSync.sclk & ~sclkPrev;
   assign sclkFall = ~pinsSync.sclk & sclkPrev;
   assign csActive = ~pinsSync.csN;

   // phase decode
   assign rxNext   = {rxShift[14:0], pinsSync.sdi};
   assign cmdDone  = (state == ST_CMD) && sclkRise && (bitCnt == 4'hF);
   assign byteDone = (state == ST_DATA) && sclkRise && (bitCnt == 4'h7);
   assign wrStrobe = byteDone && !cmd.read;
   assign softStart = wrStrobe && (curAddr == `SCR_ADDR_SERIAL_CFG) &&
                      rxNext[`SCR_BIT_SOFT_RESET];

   // streaming address step: hold beats direction
   always_comb begin
      if (userCfg[`SCR_BIT_ADDR_HOLD]) begin
         next_addr = curAddr;
      end else if (addrDir) begin
         next_addr = curAddr + 15'h0001;
      end else begin
         next_addr = curAddr - 15'h0001;
      end
   end

   // transaction sequencer; held idle while the soft reset runs,
   // since the host is expected to stay off the port meanwhile
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state  <= ST_IDLE;
         bitCnt <= 4'h0;
      end else if (softActive || !csActive) begin
         state  <= ST_IDLE;
         bitCnt <= 4'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               state  <= ST_CMD;
               bitCnt <= 4'h0;
            end
            ST_CMD: begin
               if (sclkRise) begin
                  bitCnt <= bitCnt + 4'h1;
                  if (bitCnt == 4'hF) begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (sclkRise) begin
                  bitCnt <= (bitCnt == 4'h7) ? 4'h0 : bitCnt + 4'h1;
               end
            end
            default: begin
               state  <= ST_IDLE;
               bitCnt <= 4'h0;
            end
         endcase
      end
   end

   // input shift register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rxShift <= 16'h0000;
      end else if (sclkRise && state != ST_IDLE) begin
         rxShift <= rxNext;
      end
   end

   // instruction capture and streaming address
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd     <= '0;
         curAddr <= 15'h0000;
      end else if (cmdDone) begin
         cmd     <= scr_cmd_t'(rxNext);
         curAddr <= rxNext[14:0];
      end else if (byteDone) begin
         curAddr <= next_addr;
      end
   end

   // soft reset stretcher; the bit itself is never stored
   scr_reset_gen #(
      .CYCLES  (SOFT_RST_CYCLES)
   ) u_rst (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (softStart),
      .active  (softActive)
   );
   assign devSoftReset = softActive;

   // address direction bit
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         addrDir <= `SCR_RST_ADDR_DIR;
      end else if (softActive) begin
         addrDir <= `SCR_RST_ADDR_DIR;
      end else if (wrStrobe && curAddr == `SCR_ADDR_SERIAL_CFG) begin
         addrDir <= rxNext[`SCR_BIT_ADDR_DIR];
      end
   end

   // power-state field
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         powerState <= `SCR_RST_POWER_STATE;
      end else if (softActive) begin
         powerState <= `SCR_RST_POWER_STATE;
      end else if (wrStrobe && curAddr == `SCR_ADDR_POWER_CFG) begin
         powerState <= rxNext[1:0];
      end
   end
   // values 2 and 3 both power down; 0 and 1 run full power
   assign powerDown = powerState[1];

   // user configuration; reserved bits are kept as written
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         userCfg <= `SCR_RST_USER_CFG;
      end else if (softActive) begin
         userCfg <= `SCR_RST_USER_CFG;
      end else if (wrStrobe && curAddr == `SCR_ADDR_USER_CFG) begin
         userCfg <= rxNext[7:0];
      end
   end

   // output shifter: load at each byte boundary, shift on falling edge;
   // data is sampled at the boundary, so a byte written later in the
   // same stream is not seen by an earlier read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         txShift <= 8'h00;
         spiSdo  <= 1'b0;
      end else if (cmdDone) begin
         txShift <= readByte(rxNext[14:0]);
      end else if (byteDone) begin
         txShift <= readByte(next_addr);
      end else if (sclkFall && state == ST_DATA && cmd.read) begin
         spiSdo  <= txShift[7];
         txShift <= {txShift[6:0], 1'b0};
      end
   end
   assign spiSdoOe = csActive;

   // helper read-back values, watched by the checks below; a process,
   // not assigns, so the state that the function reads is tracked
   logic [7:0] rdCfg;
   logic [7:0] rdClass;
   logic [7:0] rdPartLo;
   logic [7:0] rdPartHi;
   logic [7:0] rdRev;
   logic [7:0] rdMakerLo;
   logic [7:0] rdMakerHi;
   logic [7:0] rdReserved;
   always_comb begin
      rdCfg      = readByte(`SCR_ADDR_SERIAL_CFG);
      rdClass    = readByte(`SCR_ADDR_PART_CLASS);
      rdPartLo   = readByte(`SCR_ADDR_PART_NUM_LO);
      rdPartHi   = readByte(`SCR_ADDR_PART_NUM_HI);
      rdRev      = readByte(`SCR_ADDR_SILICON_REV);
      rdMakerLo  = readByte(`SCR_ADDR_MAKER_LO);
      rdMakerHi  = readByte(`SCR_ADDR_MAKER_HI);
      rdReserved = readByte(15'h0011);
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence softWrite_s;
      wrStrobe && curAddr == `SCR_ADDR_SERIAL_CFG &&
      rxNext[`SCR_BIT_SOFT_RESET];
   endsequence

   sequence resetRuns_s;
      devSoftReset [*2];
   endsequence

   sequence stepByte_s;
      byteDone && !userCfg[`SCR_BIT_ADDR_HOLD];
   endsequence

   soft_rst_fire_a: assert property (
      softWrite_s |=> resetRuns_s ##1 (addrDir && powerState == 2'h0 &&
                                   userCfg == 8'h00))
      else $error("soft reset did not restore registers");
   soft_bit_clear_a: assert property (
      rdCfg[`SCR_BIT_SOFT_RESET] == 1'b0)
      else $error("soft reset bit reads back set");
   step_up_a: assert property (
      (stepByte_s and addrDir) |=>
      curAddr == $past(curAddr) + 15'h0001)
      else $error("ascending step wrong");
   step_down_a: assert property (
      (stepByte_s and !addrDir) |=>
      curAddr == $past(curAddr) - 15'h0001)
      else $error("descending step wrong");
   four_wire_a: assert property (
      rdCfg[`SCR_BIT_FOUR_WIRE] && rdCfg[3:0] == 4'h0)
      else $error("four-wire indicator not set");
   power_normal_a: assert property (
      powerState < 2'h2 |-> !powerDown)
      else $error("normal state powers down");
   power_down_a: assert property (
      (wrStrobe && curAddr == `SCR_ADDR_POWER_CFG && rxNext[1] &&
       !softActive) |=> powerDown)
      else $error("power-down value not honoured");
   class_fixed_a: assert property (
      rdClass == {4'h0, PART_CLASS})
      else $error("part class read-back wrong");
   part_fixed_a: assert property (
      {rdPartHi, rdPartLo} == PART_NUMBER)
      else $error("part number read-back wrong");
   rev_fixed_a: assert property (
      rdRev == SILICON_REV)
      else $error("silicon revision read-back wrong");
   maker_fixed_a: assert property (
      {rdMakerHi, rdMakerLo} == MAKER_CODE)
      else $error("maker code read-back wrong");
   reserved_zero_a: assert property (
      rdReserved == 8'h00)
      else $error("reserved byte not zero");
   addr_hold_a: assert property (
      (byteDone && userCfg[`SCR_BIT_ADDR_HOLD]) |=> $stable(curAddr))
      else $error("held address moved");
endmodule
`default_nettype wire

// *** inc/scr_defs.svh ***
/*
 * Constants of the serial configuration register bank: byte addresses,
 * bit positions, reset values and soft reset timing.
 * Assumes the includer runs on sys_clk at 250 MHz.
 */
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

`define SCR_ADDR_SERIAL_CFG   15'h0000
`define SCR_ADDR_POWER_CFG    15'h0002
`define SCR_ADDR_PART_CLASS   15'h0003
`define SCR_ADDR_PART_NUM_LO  15'h0004
`define SCR_ADDR_PART_NUM_HI  15'h0005
`define SCR_ADDR_SILICON_REV  15'h0006
`define SCR_ADDR_MAKER_LO     15'h000C
`define SCR_ADDR_MAKER_HI     15'h000D
`define SCR_ADDR_USER_CFG     15'h0010

`define SCR_BIT_SOFT_RESET    7
`define SCR_BIT_ADDR_DIR      5
`define SCR_BIT_FOUR_WIRE     4
`define SCR_BIT_ADDR_HOLD     0

`define SCR_RST_POWER_STATE   2'h0
`define SCR_RST_ADDR_DIR      1'h1
`define SCR_RST_USER_CFG      8'h00

`define SCR_CLK_PERIOD_NS     4
`define SCR_SOFT_RST_NS       750
`define SCR_SOFT_RST_CYC      (`SCR_SOFT_RST_NS / `SCR_CLK_PERIOD_NS)

`endif

// *** inc/scr_pkg.sv ***
/*
 * Types of the serial configuration register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package scr_pkg;
   // serial pins as sampled
   typedef struct packed {
      logic sclk;
      logic csN;
      logic sdi;
   } scr_pins_t;

   // instruction phase of a transaction
   typedef struct packed {
      logic        read;
      logic [14:0] addr;
   } scr_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CMD  = 3'b010,
      ST_DATA = 3'b100
   } scr_state_t;
endpackage
`default_nettype wire

// *** rtl/scr_sync.sv ***
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module scr_sync #(
   parameter int               WIDTH   = 3,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   if (WIDTH < 1) begin : g_chk
      $error("scr_sync needs WIDTH of one or more");
   end

   // plain shift chain; stage1 feeds stage2 only
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
      end else begin
         stage1 <= asyncIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a bit changes only once stage2 and stage3 agree
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncOut <= RST_VAL;
      end else begin
         syncOut <= (stage2 & stage3) | (syncOut & (stage2 ^ stage3));
      end
   end
endmodule
`default_nettype wire

// *** rtl/scr_reset_gen.sv ***
/*
 * Soft reset pulse stretcher: holds its output for CYCLES clocks.
 * Assumes start is a one-cycle pulse on sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module scr_reset_gen #(
   parameter int CYCLES = 187
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic start,
   output logic      active
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt;

   if (CYCLES < 1) begin : g_chk
      $error("scr_reset_gen needs CYCLES of one or more");
   end

   // a new start restarts the full interval
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt    <= '0;
         active <= 1'b0;
      end else if (start) begin
         cnt    <= CW'(CYCLES);
         active <= 1'b1;
      end else if (cnt > CW'(1)) begin
         cnt    <= cnt - CW'(1);
      end else begin
         cnt    <= '0;
         active <= 1'b0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   soft_rst_begin_a: assert property (start |=> active)
      else $error("soft reset did not start");
   soft_rst_end_a: assert property (
      (active && cnt == CW'(1) && !start) |=> !active)
      else $error("soft reset did not end on time");
endmodule
`default_nettype wire

// *** verification/scr_spi_host.sv ***
/*
 * Serial host model for the register bank: mode 0 frames, msb first,
 * sixteen-bit instruction, then data bytes.
 * Assumes the bank samples sdi on sclk rise and shifts sdo on sclk fall.
 */
`timescale 1ns/100ps
`default_nettype none
module scr_spi_host (
   input  wire logic sys_clk,
   input  wire logic spiSdo,
   output logic      spiSclk,
   output logic      spiCsN,
   output logic      spiSdi
);
   logic [7:0] rdBuf [8];

   // idle bus: sclk low, chip not selected
   initial begin
      spiSclk = 1'h0;
      spiCsN = 1'h1;
      spiSdi = 1'h0;
   end

   // wait n clocks, then step just off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // one bit; 8-clock half periods leave the input filter ample margin
   task automatic bitx(input logic b, output logic s);
      spiSdi = b;
      tick(8);
      s = spiSdo;
      spiSclk = 1'h1;
      tick(8);
      spiSclk = 1'h0;
   endtask

   // whole frame; read bytes land in rdBuf, sdi carries wd
   task automatic xfer(input logic rd, input logic [14:0] adr,
                       input int n, input logic [7:0] wd [8]);
      logic [15:0] ins;
      logic        s;
      ins = {rd, adr};
      spiCsN = 1'h0;
      tick(8);
      for (int i = 15; i >= 0; i--) begin
         bitx(ins[i], s);
      end
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bitx(wd[k][i], s);
            rdBuf[k][i] = s;
         end
      end
      tick(8);
      spiCsN = 1'h1;
      spiSdi = ~spiSdi; // released line must not look stable
      tick(8);
   endtask
endmodule
`default_nettype wire

// *** verification/scr_regs_tb.sv ***
/*
 * Self-checking bench for the serial register bank.
 * Assumes the host model drives sclk, csN and sdi (the bank drives sdo) and owns frame timing.
 */
`timescale 1ns/100ps
`default_nettype none
`include "scr_defs.svh"
module scr_regs_tb
   import scr_pkg::*;
;
   // arbitrary identity values, not those of any real part
   localparam logic [3:0]  P_CLASS = 4'h9;
   localparam logic [15:0] P_NUM   = 16'h1B2D;
   localparam logic [7:0]  P_REV   = 8'h47;
   localparam logic [15:0] P_MAKER = 16'h6C3E;

   logic sys_clk, nrst, spiSclk, spiCsN, spiSdi;
   logic spiSdo, spiSdoOe, devSoftReset, powerDown;
   int   badCount, numChecks, cycles;
   logic [7:0] wd [8];

   scr_regs #(.PART_CLASS(P_CLASS), .PART_NUMBER(P_NUM),
      .SILICON_REV(P_REV), .MAKER_CODE(P_MAKER)) dut (
      .sys_clk(sys_clk), .nrst(nrst), .spiSclk(spiSclk),
      .spiCsN(spiCsN), .spiSdi(spiSdi), .spiSdo(spiSdo),
      .spiSdoOe(spiSdoOe), .devSoftReset(devSoftReset),
      .powerDown(powerDown));

   scr_spi_host host (.sys_clk(sys_clk), .spiSdo(spiSdo),
      .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi));

   initial sys_clk = 1'h0;
   always #2 sys_clk = ~sys_clk;

   // hang guard, well above the roughly 13k clocks the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         badCount++;
         $display("Error at %0t: timeout", $time);
         testDone();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [14:0] a, input int n);
      host.xfer(1'h1, a, n, wd);
   endtask

   task automatic wr1(input logic [14:0] a, input logic [7:0] v);
      wd[0] = v;
      host.xfer(1'h0, a, 1, wd);
   endtask

   // stream from 0x000 upward over part class, number and revision; maker code is read in its own frame
   task automatic test_reset_vals();
      rd(`SCR_ADDR_SERIAL_CFG, 7);
      chk8(host.rdBuf[0], 8'h30);
      chk8(host.rdBuf[1], 8'h00);
      chk8(host.rdBuf[2], 8'h00);
      chk8(host.rdBuf[3], {4'h0, P_CLASS});
      chk8(host.rdBuf[4], P_NUM[7:0]);
      chk8(host.rdBuf[5], P_NUM[15:8]);
      chk8(host.rdBuf[6], P_REV);
      rd(`SCR_ADDR_MAKER_LO, 2);
      chk8(host.rdBuf[0], P_MAKER[7:0]);
      chk8(host.rdBuf[1], P_MAKER[15:8]);
      rd(`SCR_ADDR_USER_CFG, 2);
      chk8(host.rdBuf[0], 8'h00);
      chk8(host.rdBuf[1], 8'h00);
   endtask

   // streamed all-ones writes over read-only bytes leave them intact
   task automatic test_ro_writes();
      wd = '{default: 8'hFF};
      host.xfer(1'h0, `SCR_ADDR_PART_CLASS, 4, wd);
      host.xfer(1'h0, `SCR_ADDR_MAKER_LO, 2, wd);
      wd = '{default: 8'h00};
      rd(`SCR_ADDR_PART_CLASS, 4);
      chk8(host.rdBuf[0], {4'h0, P_CLASS});
      chk8(host.rdBuf[1], P_NUM[7:0]);
      chk8(host.rdBuf[2], P_NUM[15:8]);
      chk8(host.rdBuf[3], P_REV);
      rd(`SCR_ADDR_MAKER_LO, 2);
      chk8(host.rdBuf[0], P_MAKER[7:0]);
      chk8(host.rdBuf[1], P_MAKER[15:8]);
   endtask

   // every power state value; leaves the device powered down
   task automatic test_power();
      for (int v = 0; v < 4; v++) begin
         wr1(`SCR_ADDR_POWER_CFG, 8'(v));
         chk1(powerDown, logic'(v >= 2));
         rd(`SCR_ADDR_POWER_CFG, 1);
         chk8(host.rdBuf[0], 8'(v));
      end
   endtask

   // direction bit cleared: stream steps downward
   task automatic test_descend();
      wr1(`SCR_ADDR_SERIAL_CFG, 8'h00);
      rd(`SCR_ADDR_SERIAL_CFG, 1);
      chk8(host.rdBuf[0], 8'h10);
      rd(`SCR_ADDR_SILICON_REV, 3);
      chk8(host.rdBuf[0], P_REV);
      chk8(host.rdBuf[1], P_NUM[15:8]);
      chk8(host.rdBuf[2], P_NUM[7:0]);
   endtask

   // hold bit set: address stays put with the direction bit cleared
   task automatic test_hold();
      wr1(`SCR_ADDR_USER_CFG, 8'h01);
      rd(`SCR_ADDR_SILICON_REV, 3);
      for (int k = 0; k < 3; k++) begin
         chk8(host.rdBuf[k], P_REV);
      end
      rd(`SCR_ADDR_USER_CFG, 1);
      chk8(host.rdBuf[0], 8'h01);
   endtask

   // soft reset from a changed state restores every default
   task automatic test_soft_reset();
      wr1(`SCR_ADDR_SERIAL_CFG, 8'hA0);
      chk1(devSoftReset, 1'h1);
      chk1(powerDown, 1'h0);
      host.tick(190); // 760 ns of silence before the next frame
      chk1(devSoftReset, 1'h0);
      rd(`SCR_ADDR_SERIAL_CFG, 1);
      chk8(host.rdBuf[0], 8'h30);
      rd(`SCR_ADDR_POWER_CFG, 1);
      chk8(host.rdBuf[0], 8'h00);
      rd(`SCR_ADDR_USER_CFG, 1);
      chk8(host.rdBuf[0], 8'h00);
   endtask

   task automatic testDone();
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // main sequence; order matters since each test leaves state behind
   initial begin
      nrst = 1'h0;
      badCount = 0;
      numChecks = 0;
      cycles = 0;
      wd = '{default: 8'h00};
      repeat (16) @(posedge sys_clk);
      #1;
      nrst = 1'h1;
      host.tick(8);
      chk1(spiSdoOe, 1'h0);
      chk1(devSoftReset, 1'h0);
      test_reset_vals();
      test_ro_writes();
      test_power();
      test_descend();
      test_hold();
      test_soft_reset();
      testDone();
   end
endmodule
`default_nettype wire
